// ==== design/ptc_consts.svh ====
`ifndef PTC_CONSTS_SVH
`define PTC_CONSTS_SVH

// register offsets
`define PTC_ADDR_W          4
`define PTC_OFF_CTL0        4'h0
`define PTC_OFF_CTL1        4'h1
`define PTC_OFF_CMPA_L      4'h2
`define PTC_OFF_CMPA_H      4'h3
`define PTC_OFF_PER_L       4'h4
`define PTC_OFF_PER_H       4'h5
`define PTC_OFF_CNT_L       4'h6
`define PTC_OFF_CNT_H       4'h7
`define PTC_OFF_IRQ_STAT    4'h8
`define PTC_OFF_IRQ_EN      4'h9
`define PTC_OFF_IRQ_CLR     4'hA

// control 0 fields
`define PTC_C0_ON_BIT       3
// control 1 fields
`define PTC_C1_MODE_HI      7
`define PTC_C1_MODE_LO      6
`define PTC_C1_IO_HI        5
`define PTC_C1_IO_LO        4
`define PTC_C1_OLS_BIT      3
`define PTC_C1_INV_BIT      2
`define PTC_C1_RSV_BIT      1
`define PTC_C1_CLR_BIT      0
`define PTC_C1_RESET        8'h00

// interrupt status bits
`define PTC_IRQ_MATCH_A     0
`define PTC_IRQ_MATCH_P     1
`define PTC_IRQ_OVF         2

// counter
`define PTC_CNT_W           10
`define PTC_CNT_MAX         10'h3FF
`define PTC_CNT_ZERO        10'h000
`define PTC_CNT_ONE         10'h001

`endif

// ==== design/ptc_pkg.sv ====
package ptc_pkg;

    typedef enum logic [1:0] {
        PTC_MODE_CMP   = 2'b00,
        PTC_MODE_UNDEF = 2'b01,
        PTC_MODE_PWM   = 2'b10,
        PTC_MODE_TMR   = 2'b11
    } ptc_mode_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ptc_bus_req_t;

    typedef enum logic [1:0] {
        PTC_PS_IDLE = 2'b00,
        PTC_PS_WAIT = 2'b01,
        PTC_PS_HIGH = 2'b11,
        PTC_PS_DONE = 2'b10
    } ptc_pulse_t;

    typedef struct packed {
        logic [9:0] cnt;
        logic       ovf;
    } ptc_cnt_st_t;

endpackage : ptc_pkg

// ==== design/ptc_counter.sv ====
`include "ptc_consts.svh"

module ptc_counter (
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic                 run_in,
    input  wire logic                 start_in,
    input  wire logic                 clear_in,
    output ptc_pkg::ptc_cnt_st_t      st_out
);
    import ptc_pkg::*;

    ptc_cnt_st_t st_r;
    ptc_cnt_st_t st_nxt;

    // ------------------------------------------------------------
    // 10-bit up counter with wrap
    // ------------------------------------------------------------
    always_comb begin
        st_nxt     = st_r;
        st_nxt.ovf = 1'b0;
        if (start_in || clear_in) begin
            st_nxt.cnt = `PTC_CNT_ZERO;
        end else if (run_in) begin
            st_nxt.cnt = st_r.cnt + `PTC_CNT_ONE;
            st_nxt.ovf = (st_r.cnt == `PTC_CNT_MAX);
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign st_out = st_r;

endmodule : ptc_counter

// ==== design/ptc_timer.sv ====
`include "ptc_consts.svh"

module ptc_timer (
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic [3:0]           addr_in,
    input  wire logic [7:0]           wdata_in,
    input  wire logic                 wr_in,
    input  wire logic                 rd_in,
    output logic      [7:0]           rdata_out,
    output logic                      timer_output_pin_out,
    output logic                      irq_out
);
    import ptc_pkg::*;

    typedef struct packed {
        logic       counter_on;
        logic [7:0] ctl1;
        logic [9:0] cmpa;
        logic [9:0] per;
        logic [2:0] irq_stat;
        logic [2:0] irq_en;
        logic       level;
        logic       pulse_act;
        logic       pin;
        logic [7:0] rdata;
        logic       irq;
    } ptc_state_t;

    ptc_state_t   st_r;
    ptc_state_t   st_nxt;
    ptc_bus_req_t req;
    ptc_cnt_st_t  cnt_st;
    ptc_mode_t    mode;
    logic [1:0]   io_sel;
    logic         start;
    logic         match_a;
    logic         match_p;
    logic         clr_cnt;
    logic         out_pre;
    logic         pwm_wave;
    logic         on_nxt;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign req     = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
    assign mode    = ptc_mode_t'(st_r.ctl1[`PTC_C1_MODE_HI:`PTC_C1_MODE_LO]);
    assign io_sel  = st_r.ctl1[`PTC_C1_IO_HI:`PTC_C1_IO_LO];
    assign on_nxt  = (req.wr && req.addr == `PTC_OFF_CTL0) ?
                     req.wdata[`PTC_C0_ON_BIT] : st_r.counter_on;
    assign start   = on_nxt && !st_r.counter_on;
    assign match_a = st_r.counter_on && (cnt_st.cnt == st_r.cmpa)
                     && (st_r.cmpa != `PTC_CNT_ZERO);
    assign match_p = st_r.counter_on && (cnt_st.cnt == st_r.per)
                     && (st_r.per != `PTC_CNT_ZERO);

    // ------------------------------------------------------------
    // counter clear source
    // ------------------------------------------------------------
    always_comb begin
        if (mode == PTC_MODE_PWM) begin
            clr_cnt = match_p;
        end else if (st_r.ctl1[`PTC_C1_CLR_BIT]) begin
            clr_cnt = match_a;
        end else begin
            clr_cnt = match_p; // clears on period match; wraps to zero at overflow when per is zero
        end
    end

    ptc_counter u_counter (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .run_in     (st_r.counter_on),
        .start_in   (start),
        .clear_in   (clr_cnt),
        .st_out     (cnt_st)
    );

    // ------------------------------------------------------------
    // pwm waveform
    // ------------------------------------------------------------
    always_comb begin
        case (io_sel)
            2'b00:   pwm_wave = !st_r.ctl1[`PTC_C1_OLS_BIT];
            2'b01:   pwm_wave = st_r.ctl1[`PTC_C1_OLS_BIT];
            2'b10:   pwm_wave = (cnt_st.cnt < st_r.cmpa) ? st_r.ctl1[`PTC_C1_OLS_BIT]
                                : !st_r.ctl1[`PTC_C1_OLS_BIT];
            default: pwm_wave = st_r.pulse_act ? st_r.ctl1[`PTC_C1_OLS_BIT]
                                : !st_r.ctl1[`PTC_C1_OLS_BIT];
        endcase
    end

    // ------------------------------------------------------------
    // state update
    // ------------------------------------------------------------
    always_comb begin
        st_nxt            = st_r;
        st_nxt.counter_on = on_nxt;
        st_nxt.rdata      = 8'h00;
        if (req.wr) begin
            case (req.addr)
                `PTC_OFF_CTL1:     st_nxt.ctl1 = req.wdata;
                `PTC_OFF_CMPA_L:   st_nxt.cmpa[7:0] = req.wdata;
                `PTC_OFF_CMPA_H:   st_nxt.cmpa[9:8] = req.wdata[1:0];
                `PTC_OFF_PER_L:    st_nxt.per[7:0] = req.wdata;
                `PTC_OFF_PER_H:    st_nxt.per[9:8] = req.wdata[1:0];
                `PTC_OFF_IRQ_EN:   st_nxt.irq_en = req.wdata[2:0];
                `PTC_OFF_IRQ_CLR:  st_nxt.irq_stat = st_r.irq_stat & ~req.wdata[2:0];
                default:           st_nxt.ctl1 = st_r.ctl1;
            endcase
        end
        if (req.rd) begin
            case (req.addr)
                `PTC_OFF_CTL0:     st_nxt.rdata = {4'h0, st_r.counter_on, 3'h0};
                `PTC_OFF_CTL1:     st_nxt.rdata = st_r.ctl1;
                `PTC_OFF_CMPA_L:   st_nxt.rdata = st_r.cmpa[7:0];
                `PTC_OFF_CMPA_H:   st_nxt.rdata = {6'h00, st_r.cmpa[9:8]};
                `PTC_OFF_PER_L:    st_nxt.rdata = st_r.per[7:0];
                `PTC_OFF_PER_H:    st_nxt.rdata = {6'h00, st_r.per[9:8]};
                `PTC_OFF_CNT_L:    st_nxt.rdata = cnt_st.cnt[7:0];
                `PTC_OFF_CNT_H:    st_nxt.rdata = {6'h00, cnt_st.cnt[9:8]};
                `PTC_OFF_IRQ_STAT: st_nxt.rdata = {5'h00, st_r.irq_stat};
                `PTC_OFF_IRQ_EN:   st_nxt.rdata = {5'h00, st_r.irq_en};
                default:           st_nxt.rdata = 8'h00;
            endcase
        end
        // sticky events, set wins over clear
        if (match_a) begin
            st_nxt.irq_stat[`PTC_IRQ_MATCH_A] = 1'b1;
        end
        if (match_p && !(mode != PTC_MODE_PWM && st_r.ctl1[`PTC_C1_CLR_BIT])) begin
            st_nxt.irq_stat[`PTC_IRQ_MATCH_P] = 1'b1;
        end
        if (cnt_st.ovf) begin
            st_nxt.irq_stat[`PTC_IRQ_OVF] = 1'b1;
        end
        // output level per mode
        if (start) begin
            st_nxt.level     = st_r.ctl1[`PTC_C1_OLS_BIT];
            st_nxt.pulse_act = (mode == PTC_MODE_PWM) && (io_sel == 2'b11);
        end else begin
            if (mode == PTC_MODE_CMP && match_a) begin
                case (io_sel)
                    2'b01:   st_nxt.level = 1'b0;
                    2'b10:   st_nxt.level = 1'b1;
                    2'b11:   st_nxt.level = !st_r.level;
                    default: st_nxt.level = st_r.level;
                endcase
            end
            if (match_a || !on_nxt) begin
                st_nxt.pulse_act = 1'b0;
            end
        end
        case (mode)
            PTC_MODE_CMP: out_pre = st_r.level;
            PTC_MODE_PWM: out_pre = st_r.counter_on ? pwm_wave
                                    : !st_r.ctl1[`PTC_C1_OLS_BIT];
            default:      out_pre = 1'b0;
        endcase
        if (mode == PTC_MODE_TMR || mode == PTC_MODE_UNDEF) begin
            st_nxt.pin = 1'b0;
        end else begin
            st_nxt.pin = out_pre ^ st_r.ctl1[`PTC_C1_INV_BIT];
        end
        st_nxt.irq = |(st_nxt.irq_stat & st_r.irq_en);
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_out            = st_r.rdata;
    assign timer_output_pin_out = st_r.pin;
    assign irq_out              = st_r.irq;

endmodule : ptc_timer

// ==== tb/ptc_timer_checker.sv ====
module ptc_timer_checker (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    input  wire logic [7:0] rdata_out,
    input  wire logic       timer_output_pin_out,
    input  wire logic       irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [7:0] c0_r;
    logic [7:0] c1_r;
    // ----------------
    // control shadows
    // ----------------
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            c0_r <= 8'h00;
            c1_r <= 8'h00;
        end else if (wr_in && addr_in == 4'h0) begin
            c0_r <= wdata_in;
        end else if (wr_in && addr_in == 4'h1) begin
            c1_r <= wdata_in;
        end
    end
    // ----------------
    // assertions
    // ----------------
    reset_quiet_a: assert property (disable iff (1'b0) !rst_n_in |->
        !timer_output_pin_out && !irq_out && rdata_out == 8'h00) else $error("output in reset");
    read_idle_a: assert property (!rd_in |=> rdata_out == 8'h00) else $error("stray read data");
    unmapped_zero_a: assert property (rd_in && addr_in > 4'hA |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");
    high_byte_a: assert property (rd_in && addr_in inside {4'h3, 4'h5, 4'h7} |=>
        rdata_out[7:2] == 6'h00) else $error("high byte upper bits set");
    timer_pin_a: assert property (c1_r[7:6] == 2'b11 [*3] |-> !timer_output_pin_out)
        else $error("pin driven in timer mode");
    start_level_a: assert property (wr_in && addr_in == 4'h0 &&
        wdata_in[3] && !c0_r[3] && (c1_r[7:6] == 2'b00 || c1_r[7:4] == 4'hB) |-> ##[1:3]
        timer_output_pin_out == (c1_r[3] ^ c1_r[2])) else $error("pin not at start level");
    cmp_hold_a: assert property ((c1_r[7:4] == 4'h0 && c0_r[3] && $stable(c1_r) &&
        $stable(c0_r)) [*3] |-> $stable(timer_output_pin_out)) else $error("pin moved");
    pwm_forced_a: assert property ((c1_r[7:5] == 3'b100 && c0_r[3] &&
        $stable(c1_r)) [*3] |-> timer_output_pin_out == (c1_r[3] ^ c1_r[2] ^ ~c1_r[4]))
        else $error("forced level wrong");
    cover property (c1_r[7:6] == 2'b11 && c0_r[3]);
    cover property (c1_r[7:4] == 4'hB && $rose(c0_r[3]));
    cover property (c1_r[7:5] == 3'b100 && c0_r[3]);
endmodule : ptc_timer_checker

bind ptc_timer ptc_timer_checker i_ptc_timer_checker (.sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .timer_output_pin_out(timer_output_pin_out), .irq_out(irq_out));

// ==== tb/ptc_load.sv ====
module ptc_load (
    input  wire logic sys_clk_in,
    input  wire logic clr_in,
    input  wire logic pin_in,
    output int        rises_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev_r = 1'b0;
    // counts rising edges seen by the load
    always @(posedge sys_clk_in) begin
        prev_r <= pin_in;
        rises_out <= clr_in ? 0 : rises_out + int'(pin_in && !prev_r);
    end
endmodule : ptc_load

// ==== tb/ptc_timer_bench.sv ====
module ptc_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk = 1'b0;
    logic       rst_n;
    logic       wr      = 1'b0;
    logic       rd      = 1'b0;
    logic       ld_clr  = 1'b0;
    logic [3:0] addr    = 4'h0;
    logic [7:0] wdata   = 8'h00;
    logic [7:0] rdata;
    logic       pin;
    logic       irq;
    logic [7:0] r;
    int         rises;
    int         n_errors   = 0;
    int         num_checks = 0;
    always #4 sys_clk = ~sys_clk;
    ptc_timer i_ptc_timer (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .timer_output_pin_out(pin), .irq_out(irq));
    ptc_load i_ptc_load (.sys_clk_in(sys_clk), .clr_in(ld_clr), .pin_in(pin), .rises_out(rises));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        #2 check(rdata, exp);
    endtask : rd_reg
    // status model: sticky match a, match p, overflow
    function automatic logic [7:0] stat_model(logic [7:0] c1, int a, int p, int n);
        logic clr;
        clr = c1[0] && c1[7:6] != 2'b10;
        return {5'h00, !clr && p == 0 && n > 1024, !clr && p != 0 && p <= n,
                a != 0 && a <= n && (clr || p == 0 || a <= p)};
    endfunction : stat_model
    task automatic run(input logic [7:0] c1, input int a, input int p, input int n,
                       input int lo, input int hi, input int pn);
        logic [7:0] st;
        st = stat_model(c1, a, p, n);
        wr_reg(4'h0, 8'h00);
        wr_reg(4'hA, 8'h07);
        rd_reg(4'h8, 8'h00);
        wr_reg(4'h2, a[7:0]);
        wr_reg(4'h3, 8'(a >> 8));
        wr_reg(4'h4, p[7:0]);
        wr_reg(4'h5, 8'(p >> 8));
        wr_reg(4'h1, c1);
        rd_reg(4'h1, c1);
        wr_reg(4'h0, 8'h08);
        repeat (3) @(posedge sys_clk);
        ld_clr <= 1'b1;
        @(posedge sys_clk);
        ld_clr <= 1'b0;
        repeat (n) @(posedge sys_clk);
        rd_reg(4'h8, st);
        check({7'h00, irq}, {7'h00, st != 8'h00});
        num_checks++;
        if (rises < lo || rises > hi) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, rises, lo);
        end
        if (pn >= 0) check({7'h00, pin}, pn[7:0]);
    endtask : run
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        wrap_up();
    end
    initial begin
        rst_n <= 1'b0;
        void'($urandom(60134));
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 16; i++) rd_reg(i[3:0], 8'h00);
        r = 8'($urandom);
        wr_reg(4'h2, r);
        rd_reg(4'h2, r);
        wr_reg(4'h5, 8'hFF);
        rd_reg(4'h5, 8'h03);
        wr_reg(4'h9, 8'h07);
        run(8'h31, 10, 5, 100, 3, 6, -1);
        run(8'h38, 30, 10, 100, 0, 0, 1);
        run(8'h00, 0, 0, 1100, 0, 0, 0);
        run(8'hCD, 10, 0, 100, 0, 0, 0);
        for (int v = 0; v < 2; v++) begin
            run(8'hB9 | 8'(v << 2), 8 + $urandom % 20, 50, 100, v, v, v);
        end
        run(8'hA9, 5, 20, 200, 7, 12, -1);
        run(8'h8C, 5, 20, 50, 0, 1, 1);
        run(8'h21, 10, 0, 100, 1, 1, 1);
        run(8'h1D, 10, 0, 100, 1, 1, 1);
        run(8'h90, 5, 20, 50, 0, 0, 0);
        run(8'h44, 10, 0, 50, 0, 0, 0);
        wr_reg(4'h0, 8'h00);
        wr_reg(4'h9, 8'h00);
        repeat (2) @(posedge sys_clk);
        #2 check({7'h00, irq}, 8'h00);
        wr_reg(4'h9, 8'h07);
        repeat (2) @(posedge sys_clk);
        #2 check({7'h00, irq}, 8'h01);
        wr_reg(4'hA, 8'h07);
        repeat (2) @(posedge sys_clk);
        #2 check({7'h00, irq}, 8'h00);
        wrap_up();
    end
endmodule : ptc_timer_bench
